/* hw/pecl_counter.sv */
// pecl_counter: one saturating event counter with up to two events per cycle.
// assumes events are single-cycle pulses synchronous to core_clk_i.
module pecl_counter #(
	parameter int WIDTH = 16
) (
	input wire logic core_clk_i,
	input wire logic clear_i,
	input wire logic evt_a_i,
	input wire logic evt_b_i,
	output logic [WIDTH-1:0] count_o
);
	import pecl_pkg::*;

	logic [WIDTH:0] sum;
	logic [WIDTH-1:0] all_ones;

	assign all_ones = {WIDTH{1'b1}};
	assign sum = {1'b0, count_o} + {{WIDTH{1'b0}}, evt_a_i} + {{WIDTH{1'b0}}, evt_b_i};

	// count with saturation; clear has priority (power-up, self-test, read-and-clear)
	always_ff @(posedge core_clk_i) begin
		if (clear_i) begin
			count_o <= WIDTH'(CTR_RESET_VAL);
		end else if (sum[WIDTH]) begin
			count_o <= all_ones;
		end else begin
			count_o <= sum[WIDTH-1:0];
		end
	end

	AST_SAT_HOLD: assert property (@(posedge core_clk_i) disable iff (clear_i)
		count_o == all_ones |=> count_o == all_ones)
		else $error("counter wrapped after saturating");

endmodule : pecl_counter

/* hw/pecl_log_page.sv */
// pecl_log_page: event counters plus a streamed 512-byte counter log page.
// assumes event inputs are one-cycle pulses from the link layer; the page is sent
// one byte per cycle while page_ready_i is high.
module pecl_log_page (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic cmd_err_icrc_i,
	input wire logic tx_data_rerr_i,
	input wire logic rx_data_rerr_i,
	input wire logic tx_nondata_rerr_i,
	input wire logic rx_nondata_rerr_i,
	input wire logic phy_ready_i,
	input wire logic sig_fis_rok_i,
	input wire logic rx_rerr_crc_i,
	input wire logic rx_rerr_other_i,
	input wire logic bist_activate_i,
	input wire logic read_req_i,
	input wire logic read_clear_i,
	input wire logic page_ready_i,
	output logic page_valid_o,
	output logic [7:0] page_data_o,
	output logic page_last_o,
	output logic busy_o
);
	import pecl_pkg::*;

	logic [CTR_W-1:0] ctr [NUM_CTRS];
	logic [CTR_W-1:0] snap_q [NUM_CTRS];
	logic [NUM_CTRS-1:0] evt_a;
	logic [NUM_CTRS-1:0] evt_b;
	logic phy_ready_q;
	logic ctr_clear;
	logic clear_pend_q;
	pecl_state_t state_q;
	logic [BYTE_IDX_W-1:0] idx_q;
	logic [7:0] sum_q;
	logic [7:0] cur_byte;
	logic beat;

	////////////////////////////////////////////////////////////////
	// event decode
	// rising link-ready edge
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			phy_ready_q <= 1'b0;
		end else begin
			phy_ready_q <= phy_ready_i;
		end
	end

	always_comb begin
		evt_a = '0;
		evt_b = '0;
		evt_a[0] = cmd_err_icrc_i;
		evt_a[1] = tx_data_rerr_i;
		evt_b[1] = rx_data_rerr_i;
		evt_a[2] = tx_nondata_rerr_i;
		evt_b[2] = rx_nondata_rerr_i;
		evt_a[3] = phy_ready_i & ~phy_ready_q;
		evt_a[4] = sig_fis_rok_i;
		evt_a[5] = rx_rerr_crc_i;
		evt_a[6] = rx_rerr_other_i;
	end

	////////////////////////////////////////////////////////////////
	// counters; reset_i is power-up only, link resets never reach here
	// clear sources
	assign ctr_clear = reset_i | bist_activate_i | clear_pend_q;

	for (genvar g = 0; g < NUM_CTRS; g++) begin : g_ctr
		pecl_counter #(
			.WIDTH(CTR_W)
		) u_ctr (
			.core_clk_i(core_clk_i),
			.clear_i(ctr_clear),
			.evt_a_i(evt_a[g]),
			.evt_b_i(evt_b[g]),
			.count_o(ctr[g])
		);
	end

	////////////////////////////////////////////////////////////////
	// page byte function of the snapshot
	// entry order fixed here
	function automatic logic [11:0] slot_evt(input int s);
		case (s)
			0: slot_evt = EVT_ICRC_CMD;
			1: slot_evt = EVT_RERR_DATA;
			2: slot_evt = EVT_RERR_NONDATA;
			3: slot_evt = EVT_LINK_UP;
			4: slot_evt = EVT_SIG_OK;
			5: slot_evt = EVT_RX_CRC;
			6: slot_evt = EVT_RX_OTHER;
			default: slot_evt = EVT_END;
		endcase
	endfunction

	// entries are 4 bytes: id lo, id hi, value lo, value hi (little endian)
	always_comb begin
		logic [15:0] id;
		logic [15:0] val;
		int slot;
		id = '0;
		val = '0;
		slot = (int'(idx_q) - HDR_BYTES) / ENTRY_BYTES;
		cur_byte = 8'h00;
		// header and tail reserved read zero
		if (idx_q >= 9'(HDR_BYTES) && idx_q < LIST_END_IDX && slot < NUM_CTRS) begin
			// width code 1h, vendor bit clear
			id = pecl_ident(SIZE_16, slot_evt(slot));
			// 16-bit physical counter fills the 16-bit field, saturates to all ones
			val = snap_q[slot];
			case (idx_q[1:0])
				2'd0: cur_byte = id[7:0];
				2'd1: cur_byte = id[15:8];
				2'd2: cur_byte = val[7:0];
				default: cur_byte = val[15:8];
			endcase
		end
		// slot after last counter carries zero id, then all zero
		if (idx_q == CKSUM_IDX) begin
			cur_byte = 8'(-sum_q);
		end
	end

	////////////////////////////////////////////////////////////////
	// read sequencer
	assign beat = (state_q == PECL_SEND) && (~page_valid_o || page_ready_i);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_q <= PECL_IDLE;
			idx_q <= '0;
			sum_q <= 8'h00;
			clear_pend_q <= 1'b0;
		end else begin
			clear_pend_q <= 1'b0;
			unique case (state_q)
				PECL_IDLE: begin
					if (read_req_i) begin
						state_q <= PECL_SNAP;
					end
				end
				PECL_SNAP: begin
					state_q <= PECL_SEND;
					idx_q <= '0;
					sum_q <= 8'h00;
				end
				PECL_SEND: begin
					if (beat) begin
						sum_q <= sum_q + cur_byte;
						idx_q <= idx_q + 9'd1;
						if (idx_q == CKSUM_IDX) begin
							state_q <= PECL_DONE;
						end
					end
				end
				PECL_DONE: begin
					if (~page_valid_o) begin
						clear_pend_q <= read_clear_i;
						state_q <= PECL_IDLE;
					end
				end
			endcase
		end
	end

	// snapshot register; events during the read still count live
	always_ff @(posedge core_clk_i) begin
		if (state_q == PECL_SNAP) begin
			for (int i = 0; i < NUM_CTRS; i++) begin
				snap_q[i] <= ctr[i];
			end
		end
	end

	// output byte stream
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			page_valid_o <= 1'b0;
			page_data_o <= 8'h00;
			page_last_o <= 1'b0;
		end else if (beat) begin
			page_valid_o <= 1'b1;
			page_data_o <= cur_byte;
			page_last_o <= (idx_q == CKSUM_IDX);
		end else if (page_ready_i) begin
			page_valid_o <= 1'b0;
			page_last_o <= 1'b0;
		end
	end

	// busy status
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= (state_q != PECL_IDLE) || read_req_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	AST_HDR_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i)
		beat && idx_q < 9'(HDR_BYTES) |=> page_data_o == 8'h00)
		else $error("header byte not zero");

	AST_FIRST_ID: assert property (@(posedge core_clk_i) disable iff (reset_i)
		beat && idx_q == 9'd5 |=> page_data_o == 8'h10)
		else $error("first identifier width code wrong");

	AST_TAIL_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i)
		beat && idx_q >= LIST_END_IDX && idx_q != CKSUM_IDX |=> page_data_o == 8'h00)
		else $error("byte after list end not zero");

	AST_CKSUM: assert property (@(posedge core_clk_i) disable iff (reset_i)
		beat && idx_q == CKSUM_IDX |=> page_last_o && 8'(page_data_o + $past(sum_q)) == 8'h00)
		else $error("page checksum wrong");

	AST_BIST_CLR: assert property (@(posedge core_clk_i) disable iff (reset_i)
		bist_activate_i |=> ctr[0] == '0 && ctr[6] == '0)
		else $error("self-test frame did not clear counters");

	AST_LINK_UP: assert property (@(posedge core_clk_i) disable iff (reset_i || ctr_clear)
		phy_ready_i && !phy_ready_q && ctr[3] != 16'hFFFF |=> ctr[3] == $past(ctr[3]) + 16'd1)
		else $error("link-ready transition not counted");

	AST_DUAL: assert property (@(posedge core_clk_i) disable iff (reset_i || ctr_clear)
		tx_data_rerr_i && rx_data_rerr_i && ctr[1] < 16'hFFFE
		|=> ctr[1] == $past(ctr[1]) + 16'd2)
		else $error("data negative acks not summed");

	AST_SNAP: assert property (@(posedge core_clk_i) disable iff (reset_i)
		state_q == PECL_SNAP |=> snap_q[0] == $past(ctr[0]))
		else $error("snapshot mismatch");

	AST_RD_CLR: assert property (@(posedge core_clk_i) disable iff (reset_i)
		clear_pend_q |=> ctr[4] == '0)
		else $error("read-and-clear did not clear");

	AST_HOLD_BYTE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		page_valid_o && !page_ready_i
		|=> page_valid_o && $stable(page_data_o) && $stable(page_last_o))
		else $error("stalled page byte moved");

	AST_LAST_VALID: assert property (@(posedge core_clk_i) disable iff (reset_i)
		page_last_o |-> page_valid_o)
		else $error("last flag without valid byte");

	AST_ID_HI: assert property (@(posedge core_clk_i) disable iff (reset_i)
		beat && idx_q >= 9'(HDR_BYTES) && idx_q < LIST_END_IDX && idx_q[1:0] == 2'd1
		|=> page_data_o[7:4] == {1'b0, SIZE_16})
		else $error("identifier vendor bit or width code wrong");

	AST_SNAP_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		state_q == PECL_SEND |=> $stable(snap_q[0]) && $stable(snap_q[6]))
		else $error("snapshot changed during page send");

	AST_POWER_CLR: assert property (@(posedge core_clk_i)
		reset_i |=> ctr[6] == '0 && !page_valid_o && !busy_o)
		else $error("power-up reset did not clear");

	AST_ICRC: assert property (@(posedge core_clk_i) disable iff (reset_i || ctr_clear)
		cmd_err_icrc_i && ctr[0] != 16'hFFFF |=> ctr[0] == $past(ctr[0]) + 16'd1)
		else $error("interface crc command not counted");

	AST_SIG_OK: assert property (@(posedge core_clk_i) disable iff (reset_i || ctr_clear)
		sig_fis_rok_i && ctr[4] != 16'hFFFF |=> ctr[4] == $past(ctr[4]) + 16'd1)
		else $error("acknowledged signature not counted");

	AST_NONDATA: assert property (@(posedge core_clk_i) disable iff (reset_i || ctr_clear)
		tx_nondata_rerr_i && rx_nondata_rerr_i && ctr[2] < 16'hFFFE
		|=> ctr[2] == $past(ctr[2]) + 16'd2)
		else $error("non-data negative acks not summed");

endmodule : pecl_log_page

/* hw/pecl_pkg.sv */
// pecl_pkg: constants shared by the event counter log page block.
// assumes one 25 MHz clock; all page geometry and identifiers live here.
package pecl_pkg;

	localparam int PAGE_BYTES = 512;
	localparam int HDR_BYTES = 4;
	localparam int NUM_CTRS = 7;
	localparam int CTR_W = 16;
	localparam int ENTRY_BYTES = 4;
	localparam int BYTE_IDX_W = 9;
	localparam int CLK_PERIOD_NS = 40;
	localparam logic [8:0] CKSUM_IDX = 9'h1FF;
	localparam logic [8:0] LIST_END_IDX = 9'h020;
	localparam logic [CTR_W-1:0] CTR_RESET_VAL = 16'h0000;

	// identifier layout: bit 15 vendor, bits 14:12 width code, 11:0 event
	localparam int ID_VENDOR_BIT = 15;
	localparam int ID_SIZE_LSB = 12;
	localparam logic [2:0] SIZE_16 = 3'h1;
	localparam logic [2:0] SIZE_32 = 3'h2;
	localparam logic [2:0] SIZE_48 = 3'h3;
	localparam logic [2:0] SIZE_64 = 3'h4;

	localparam logic [11:0] EVT_END = 12'h000;
	localparam logic [11:0] EVT_ICRC_CMD = 12'h001;
	localparam logic [11:0] EVT_RERR_DATA = 12'h002;
	localparam logic [11:0] EVT_RERR_NONDATA = 12'h005;
	localparam logic [11:0] EVT_LINK_UP = 12'h009;
	localparam logic [11:0] EVT_SIG_OK = 12'h00A;
	localparam logic [11:0] EVT_RX_CRC = 12'h00B;
	localparam logic [11:0] EVT_RX_OTHER = 12'h00D;

	// read-log request states
	typedef enum logic [1:0] {
		PECL_IDLE = 2'b00,
		PECL_SNAP = 2'b01,
		PECL_SEND = 2'b10,
		PECL_DONE = 2'b11
	} pecl_state_t;

	// full identifier from width code and event number
	function automatic logic [15:0] pecl_ident(input logic [2:0] sz, input logic [11:0] evt);
		pecl_ident = {1'b0, sz, evt};
	endfunction

endpackage : pecl_pkg

/* testbench/pecl_host_sink.sv */
// pecl_host_sink: host side of the log page stream, stores one whole page.
// assumes the bench pulses start_i together with each read request.
module pecl_host_sink (
	input wire logic core_clk_i,
	input wire logic start_i,
	input wire logic page_valid_i,
	input wire logic [7:0] page_data_i,
	input wire logic page_last_i,
	output logic page_ready_o,
	output logic page_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] page_q [512];
	int idx_q = 0;
	int last_q = 0;
	int cyc_q = 0;
	initial page_ready_o = 1'b0;
	initial page_done_o = 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	// stall one cycle in three, so a held byte must stay put
	always @(negedge core_clk_i) begin
		cyc_q <= cyc_q + 1;
		page_ready_o <= (cyc_q % 3) != 0;
	end
	always @(posedge core_clk_i) begin
		if (start_i) begin
			idx_q <= 0;
			page_done_o <= 1'b0;
		end else if (page_valid_i && page_ready_o) begin
			page_q[idx_q % 512] <= page_data_i;
			idx_q <= idx_q + 1;
			if (page_last_i) begin
				last_q <= idx_q;
				page_done_o <= 1'b1;
			end
		end
	end
endmodule // pecl_host_sink

/* testbench/tb_phy_event_counter_log.sv */
// tb_phy_event_counter_log: directed checks of the event counters and the log page.
// assumes pecl_pkg constants; the host sink model takes the byte stream.
`define PECL_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb_phy_event_counter_log import pecl_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] evt_v = 8'h00;
	logic phy_ready_i = 1'b0;
	logic bist_activate_i = 1'b0;
	logic read_req_i = 1'b0;
	logic read_clear_i = 1'b0;
	logic sink_start = 1'b0;
	logic page_ready, page_valid, page_last, busy, done;
	logic [7:0] page_data;
	logic [15:0] exp_cnt [7];
	logic [11:0] evts [7] = '{EVT_ICRC_CMD, EVT_RERR_DATA, EVT_RERR_NONDATA, EVT_LINK_UP,
		EVT_SIG_OK, EVT_RX_CRC, EVT_RX_OTHER};
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////////
	// event bits: 0 icrc, 1-2 data nak, 3-4 non-data nak, 5 signature, 6 crc, 7 other
	pecl_log_page uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.cmd_err_icrc_i(evt_v[0]), .tx_data_rerr_i(evt_v[1]), .rx_data_rerr_i(evt_v[2]),
		.tx_nondata_rerr_i(evt_v[3]), .rx_nondata_rerr_i(evt_v[4]),
		.phy_ready_i(phy_ready_i), .sig_fis_rok_i(evt_v[5]), .rx_rerr_crc_i(evt_v[6]),
		.rx_rerr_other_i(evt_v[7]), .bist_activate_i(bist_activate_i),
		.read_req_i(read_req_i), .read_clear_i(read_clear_i), .page_ready_i(page_ready),
		.page_valid_o(page_valid), .page_data_o(page_data), .page_last_o(page_last),
		.busy_o(busy));
	pecl_host_sink host (.core_clk_i(core_clk_i), .start_i(sink_start), .page_valid_i(page_valid),
		.page_data_i(page_data), .page_last_i(page_last), .page_ready_o(page_ready),
		.page_done_o(done));
	////////////////////////////////////////////////////////////////////////////////
	// free-running clock
	initial begin
		forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
	end
	// hang guard, well above the saturation run
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// wait one cycle, then hold an event mask for n cycles and clear it on return
	task automatic burst(input logic [7:0] m, input int n);
		@(negedge core_clk_i);
		evt_v = m;
		repeat (n) @(negedge core_clk_i);
		evt_v = 8'h00;
	endtask
	// expected page byte from the expected counts
	function automatic logic [7:0] exp_byte(input int i);
		logic [15:0] id;
		int k;
		k = (i - 4) / 4;
		if (i < HDR_BYTES || i >= HDR_BYTES + ENTRY_BYTES * NUM_CTRS) return 8'h00;
		id = {1'b0, SIZE_16, evts[k]};
		case ((i - 4) % 4)
			0: return id[7:0];
			1: return id[15:8];
			2: return exp_cnt[k][7:0];
			default: return exp_cnt[k][15:8];
		endcase
	endfunction
	// request one page, wait for it, judge every byte
	task automatic read_page(input logic clr);
		logic [7:0] sum;
		int n;
		sum = 8'h00;
		@(negedge core_clk_i);
		sink_start = 1'b1;
		read_clear_i = clr;
		read_req_i = 1'b1;
		@(negedge core_clk_i);
		sink_start = 1'b0;
		read_req_i = 1'b0;
		`PECL_CHK("busy at request", 1'b1, busy)
		for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge core_clk_i);
		`PECL_CHK("page done", 1'b1, done)
		for (n = 0; n < 8 && busy !== 1'b0; n++) @(negedge core_clk_i);
		`PECL_CHK("busy after page", 1'b0, busy)
		repeat (2) @(negedge core_clk_i);
		read_clear_i = 1'b0;
		for (n = 0; n < PAGE_BYTES - 1; n++) begin
			sum += host.page_q[n];
			`PECL_CHK("page byte", exp_byte(n), host.page_q[n])
		end
		`PECL_CHK("checksum", 8'(-sum), host.page_q[511])
		`PECL_CHK("last index", 511, host.last_q)
	endtask
	task automatic set_exp(input logic [15:0] v);
		foreach (exp_cnt[k]) exp_cnt[k] = v;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_idle();
		set_exp(CTR_RESET_VAL);
		read_page(1'b0);
	endtask
	// back-to-back events, paired naks add two, link up edges
	task automatic t_events();
		burst(8'hFF, 3);
		burst(8'h04, 1);
		burst(8'h08, 2);
		repeat (2) begin
			@(negedge core_clk_i);
			phy_ready_i = 1'b1;
			repeat (3) @(negedge core_clk_i);
			phy_ready_i = 1'b0;
			repeat (3) @(negedge core_clk_i);
		end
		exp_cnt = '{16'h0003, 16'h0007, 16'h0008, 16'h0002, 16'h0003, 16'h0003, 16'h0003};
		read_page(1'b0);
		read_page(1'b0);
	endtask
	// read-and-clear returns values first
	task automatic t_clear();
		read_page(1'b1);
		set_exp(CTR_RESET_VAL);
		read_page(1'b0);
	endtask
	// self-test frame clears, even against an event in that cycle
	task automatic t_bist();
		burst(8'h41, 2);
		@(negedge core_clk_i);
		bist_activate_i = 1'b1;
		evt_v = 8'h01;
		@(negedge core_clk_i);
		bist_activate_i = 1'b0;
		evt_v = 8'h00;
		read_page(1'b0);
	endtask
	task automatic t_saturate();
		burst(8'h01, 65540);
		exp_cnt[0] = 16'hFFFF;
		read_page(1'b0);
	endtask
	// power-up reset loses the counts
	task automatic t_power();
		burst(8'h80, 2);
		@(negedge core_clk_i);
		reset_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		reset_i = 1'b0;
		set_exp(CTR_RESET_VAL);
		read_page(1'b0);
	endtask
	// main sequence
	initial begin
		repeat (12) @(negedge core_clk_i);
		reset_i = 1'b0;
		t_idle();
		t_events();
		t_clear();
		t_bist();
		t_saturate();
		t_power();
		complete_run();
	end
endmodule // tb_phy_event_counter_log
